// ==== design/ccs_exec_top.sv ====
/*
  Execution block for the byte complement and compare-skip instructions,
  with an AXI4-Lite register file, data memory and quarter-cycle sequencing.
  Assumes an AXI4-Lite master on clk_sys with one write and one read at most.
*/
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ccs_exec_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ccs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ccs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] quarter;
  ccs_state_type state_r, state_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic twoWord_r, twoWord_nxt;
  logic extEn_r, extEn_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [3:0] bank_r, bank_nxt;
  logic zero_r, zero_nxt;
  logic msb_r, msb_nxt;
  logic [11:0] idxBase_r, idxBase_nxt;
  logic [11:0] memAddr_r, memAddr_nxt;
  logic [7:0] result_r, result_nxt;
  logic equal_r, equal_nxt;
  logic skip_r, skip_nxt;
  logic [1:0] nopLeft_r, nopLeft_nxt;
  logic [7:0] cycles_r, cycles_nxt;
  logic awTaken_r, awTaken_nxt;
  logic wTaken_r, wTaken_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] fOfs;
  logic [11:0] opAddr;
  logic [11:0] memA;
  logic memWe;
  logic [7:0] memWd;
  logic [7:0] memRd;
  logic doWrite;
  logic busy;
  logic execQ4Inv;
  logic [31:0] wrMerged;
  logic [31:0] rdMux;
  logic rdHit;

  // True for every offset the register file answers.
  function automatic logic isMapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    return (w == OFS_CTRL) || (w == OFS_INSTR) || (w == OFS_ACC) ||
           (w == OFS_BANK) || (w == OFS_FLAGS) || (w == OFS_STAT) ||
           (w == OFS_MADDR) || (w == OFS_MDATA) || (w == OFS_IDX);
  endfunction : isMapped

  // ----------------------------------------------------------------
  // Quarter phase and data memory
  // ----------------------------------------------------------------
  ccs_quarter_gen uQuarter (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .quarter_r(quarter)
  );

  ccs_data_mem uMem (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .addr(memA),
    .wrEn(memWe),
    .wrData(memWd),
    .rdData_r(memRd)
  );

  // ----------------------------------------------------------------
  // Operand address and memory port
  // ----------------------------------------------------------------
  // Effective address from the bank bit, extended mode and the offset.
  always_comb begin
    fOfs = instr_r[7:0];
    if (instr_r[BANKSEL_BIT]) begin
      opAddr = {bank_r, fOfs};
    end else if (extEn_r && (fOfs <= ILO_LIMIT)) begin
      opAddr = 12'(idxBase_r + {4'h0, fOfs});
    end else if (fOfs < ACCESS_SPLIT) begin
      opAddr = {ACCESS_LO_BANK, fOfs};
    end else begin
      opAddr = {ACCESS_HI_BANK, fOfs};
    end
  end

  // The executing instruction owns the memory; software uses it when idle.
  assign busy = (state_r != IDLE_S);
  assign doWrite = awTaken_r && wTaken_r;
  assign execQ4Inv = (state_r == EXEC_S) && (quarter == Q_4) && isInvert(instr_r);
  assign memA = (state_r == EXEC_S) ? opAddr : memAddr_r;
  assign memWe = (execQ4Inv && instr_r[DEST_BIT]) ||
                 (doWrite && !busy && ({awAddr_r[7:2], 2'h0} == OFS_MDATA) && wStrb_r[0]);
  assign memWd = (state_r == EXEC_S) ? result_r : wData_r[7:0];

  // Byte-lane merge of the write data over the register being written.
  always_comb begin
    wrMerged = '0;
    unique case ({awAddr_r[7:2], 2'h0})
      OFS_CTRL: wrMerged[CTRL_EXT_BIT] = extEn_r;
      OFS_INSTR: wrMerged = {15'h0000, twoWord_r, instr_r};
      OFS_ACC: wrMerged[7:0] = acc_r;
      OFS_BANK: wrMerged[3:0] = bank_r;
      OFS_FLAGS: wrMerged[FLAG_MSB_BIT:FLAG_ZERO_BIT] = {msb_r, zero_r};
      OFS_MADDR: wrMerged[11:0] = memAddr_r;
      OFS_IDX: wrMerged[11:0] = idxBase_r;
      default: wrMerged = '0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (wStrb_r[i]) begin
        wrMerged[i*8 +: 8] = wData_r[i*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Execution sequence and register state
  // ----------------------------------------------------------------
  // Software writes land only while idle; the sequence runs Q1 to Q4.
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    twoWord_nxt = twoWord_r;
    extEn_nxt = extEn_r;
    acc_nxt = acc_r;
    bank_nxt = bank_r;
    zero_nxt = zero_r;
    msb_nxt = msb_r;
    idxBase_nxt = idxBase_r;
    memAddr_nxt = memAddr_r;
    result_nxt = result_r;
    equal_nxt = equal_r;
    skip_nxt = skip_r;
    nopLeft_nxt = nopLeft_r;
    cycles_nxt = cycles_r;
    unique case (state_r)
      IDLE_S: begin
        if (doWrite) begin
          unique case ({awAddr_r[7:2], 2'h0})
            OFS_CTRL: extEn_nxt = wrMerged[CTRL_EXT_BIT];
            OFS_INSTR: begin
              instr_nxt = wrMerged[15:0];
              twoWord_nxt = wrMerged[INSTR_TWO_BIT];
              cycles_nxt = '0;
              skip_nxt = 1'h0;
              state_nxt = ARM_S;
            end
            OFS_ACC: acc_nxt = wrMerged[7:0];
            OFS_BANK: bank_nxt = wrMerged[3:0];
            OFS_FLAGS: begin
              zero_nxt = wrMerged[FLAG_ZERO_BIT];
              msb_nxt = wrMerged[FLAG_MSB_BIT];
            end
            OFS_MADDR: memAddr_nxt = wrMerged[11:0];
            OFS_IDX: idxBase_nxt = wrMerged[11:0];
            default: begin
            end
          endcase
        end
      end
      ARM_S: begin
        // Start on the next Q1 so that one cycle is exactly four quarters.
        if (quarter == Q_4) begin
          state_nxt = EXEC_S;
        end
      end
      EXEC_S: begin
        if (quarter == Q_3) begin
          // Process: complement, or unsigned difference for the compare.
          result_nxt = isInvert(instr_r) ? ~memRd : 8'(memRd - acc_r);
          equal_nxt = (8'(memRd - acc_r) == 8'h00);
        end
        if (quarter == Q_4) begin
          cycles_nxt = 8'(cycles_r + 8'h01);
          state_nxt = IDLE_S;
          if (isInvert(instr_r)) begin
            zero_nxt = (result_r == 8'h00);
            msb_nxt = result_r[7];
            if (!instr_r[DEST_BIT]) begin
              acc_nxt = result_r;
            end
          end else if (isSkipEq(instr_r) && equal_r) begin
            skip_nxt = 1'h1;
            nopLeft_nxt = twoWord_r ? NOP_TWO_WORD : NOP_ONE_WORD;
            state_nxt = NOP_S;
          end
        end
      end
      NOP_S: begin
        // Each discarded word costs one full no-operation cycle.
        if (quarter == Q_4) begin
          cycles_nxt = 8'(cycles_r + 8'h01);
          nopLeft_nxt = 2'(nopLeft_r - 2'h1);
          if (nopLeft_r == NOP_ONE_WORD) begin
            state_nxt = IDLE_S;
          end
        end
      end
    endcase
  end

  // Execution and register state flip-flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= IDLE_S;
      instr_r <= '0;
      twoWord_r <= 1'h0;
      extEn_r <= 1'h0;
      acc_r <= '0;
      bank_r <= '0;
      zero_r <= 1'h0;
      msb_r <= 1'h0;
      idxBase_r <= '0;
      memAddr_r <= '0;
      result_r <= '0;
      equal_r <= 1'h0;
      skip_r <= 1'h0;
      nopLeft_r <= '0;
      cycles_r <= '0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      twoWord_r <= twoWord_nxt;
      extEn_r <= extEn_nxt;
      acc_r <= acc_nxt;
      bank_r <= bank_nxt;
      zero_r <= zero_nxt;
      msb_r <= msb_nxt;
      idxBase_r <= idxBase_nxt;
      memAddr_r <= memAddr_nxt;
      result_r <= result_nxt;
      equal_r <= equal_nxt;
      skip_r <= skip_nxt;
      nopLeft_r <= nopLeft_nxt;
      cycles_r <= cycles_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !awTaken_r && !bvalid_r;
  assign s_axi_wready = !wTaken_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Read data for the requested offset; unmapped reads give zero.
  always_comb begin
    rdMux = '0;
    rdHit = isMapped(s_axi_araddr);
    unique case ({s_axi_araddr[7:2], 2'h0})
      OFS_CTRL: rdMux[CTRL_EXT_BIT] = extEn_r;
      OFS_INSTR: rdMux = {15'h0000, twoWord_r, instr_r};
      OFS_ACC: rdMux[7:0] = acc_r;
      OFS_BANK: rdMux[3:0] = bank_r;
      OFS_FLAGS: rdMux[FLAG_MSB_BIT:FLAG_ZERO_BIT] = {msb_r, zero_r};
      OFS_STAT: begin
        rdMux[STAT_BUSY_BIT] = busy;
        rdMux[STAT_SKIP_BIT] = skip_r;
        rdMux[STAT_CYC_LSB +: 8] = cycles_r;
      end
      OFS_MADDR: rdMux[11:0] = memAddr_r;
      OFS_MDATA: rdMux[7:0] = memRd;
      OFS_IDX: rdMux[11:0] = idxBase_r;
      default: rdMux = '0;
    endcase
  end

  // Address and data are taken in either order; the response follows both.
  always_comb begin
    awTaken_nxt = awTaken_r;
    wTaken_nxt = wTaken_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awTaken_nxt = 1'h1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wTaken_nxt = 1'h1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (doWrite) begin
      awTaken_nxt = 1'h0;
      wTaken_nxt = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt = isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'h0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'h1;
      rdata_nxt = rdMux;
      rresp_nxt = rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'h0;
    end
  end

  // Bus handshake flip-flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awTaken_r <= 1'h0;
      wTaken_r <= 1'h0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid_r <= 1'h0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'h0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      awTaken_r <= awTaken_nxt;
      wTaken_r <= wTaken_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  AST_INV_RESULT: assert property (
    (state_r == EXEC_S && quarter == Q_3 && isInvert(instr_r)) |=> result_r == ~$past(memRd))
    else $error("Complement result does not match the byte read.");
  AST_INV_FLAGS: assert property (
    execQ4Inv |=> (zero_r == ($past(result_r) == 8'h00)) && (msb_r == $past(result_r[7])))
    else $error("Sign or zero flag not taken from the complement.");
  AST_DEST_ACC: assert property (
    (execQ4Inv && !instr_r[DEST_BIT]) |-> !memWe ##1 acc_r == $past(result_r))
    else $error("Accumulator destination not honoured.");
  AST_DEST_MEM: assert property (
    (execQ4Inv && instr_r[DEST_BIT]) |-> (memWe && memWd == result_r && memA == opAddr) ##1 $stable(acc_r))
    else $error("Byte write-back destination not honoured.");
  AST_BANK_SEL: assert property (
    (state_r == EXEC_S && instr_r[BANKSEL_BIT]) |-> memA == {bank_r, instr_r[7:0]})
    else $error("Banked address does not use the bank pointer.");
  AST_ILO_ADDR: assert property (
    (state_r == EXEC_S && !instr_r[BANKSEL_BIT] && extEn_r && instr_r[7:0] <= ILO_LIMIT)
    |-> memA == 12'(idxBase_r + {4'h0, instr_r[7:0]}))
    else $error("Indexed offset address is wrong.");
  AST_ONE_CYCLE: assert property (
    (state_r == ARM_S && quarter == Q_4 && isInvert(instr_r)) |=> (state_r == EXEC_S)[*4] ##1 state_r == IDLE_S)
    else $error("Complement did not take exactly one cycle.");
  AST_CMP_NOFLAG: assert property (
    (state_r == EXEC_S && isSkipEq(instr_r)) |-> !memWe ##1 ($stable(acc_r) && $stable(zero_r) && $stable(msb_r)))
    else $error("Compare changed a flag, the accumulator or memory.");
  AST_SKIP_ONE: assert property (
    (state_r == EXEC_S && quarter == Q_4 && isSkipEq(instr_r) && equal_r && !twoWord_r)
    |=> (state_r == NOP_S)[*4] ##1 (state_r == IDLE_S && cycles_r == 8'h02))
    else $error("Equal compare did not insert one no-operation cycle.");
  AST_SKIP_TWO: assert property (
    (state_r == EXEC_S && quarter == Q_4 && isSkipEq(instr_r) && equal_r && twoWord_r)
    |=> (state_r == NOP_S)[*8] ##1 (state_r == IDLE_S && cycles_r == 8'h03))
    else $error("Skip over a two-word instruction did not take three cycles.");
  AST_NO_SKIP: assert property (
    (state_r == EXEC_S && quarter == Q_4 && isSkipEq(instr_r) && !equal_r)
    |=> (state_r == IDLE_S && !skip_r && cycles_r == 8'h01))
    else $error("Unequal compare inserted a no-operation cycle.");
endmodule : ccs_exec_top
`default_nettype wire

// ==== design/ccs_pkg.sv ====
/*
  Shared constants, types and helper functions for the execution block of the
  invert_byte_op and skip_if_equal_op instructions.
  Assumes a single core clock and an AXI4-Lite register bus of 32-bit words.
*/
// What this block does
// - invert_byte_op complements the addressed byte and updates sign and zero flags.
// - Destination select 0 writes the accumulator, 1 writes the byte back.
// - Bank bit 0 uses the shared access bank, 1 uses bank_pointer_reg.
// - Extended set, bank bit 0 and offset up to 95 use indexed offset addressing.
// - invert_byte_op is one word, one cycle: decode, read, process, write.
// - skip_if_equal_op subtracts unsigned, writes nothing and leaves flags alone.
// - On equality the next instruction becomes a no-operation; two cycles total.
// - Skipping a two-word instruction costs three cycles, one no-operation per word.
package ccs_pkg;

  // ----------------------------------------------------------------
  // Bus and memory geometry
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam int MEM_AW = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MADDR = 8'h18;
  localparam logic [7:0] OFS_MDATA = 8'h1C;
  localparam logic [7:0] OFS_IDX = 8'h20;
  localparam int CTRL_EXT_BIT = 0;
  localparam int INSTR_TWO_BIT = 16;
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_MSB_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int STAT_CYC_LSB = 8;

  // ----------------------------------------------------------------
  // Instruction encoding and addressing
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_INVERT = 6'h07;
  localparam logic [6:0] OPC_SKIPEQ = 7'h31;
  localparam int DEST_BIT = 9;
  localparam int BANKSEL_BIT = 8;
  localparam logic [7:0] ILO_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // ----------------------------------------------------------------
  // Quarter cycles and no-operation counts
  // ----------------------------------------------------------------
  localparam logic [1:0] Q_1 = 2'h0;
  localparam logic [1:0] Q_3 = 2'h2;
  localparam logic [1:0] Q_4 = 2'h3;
  localparam logic [1:0] NOP_ONE_WORD = 2'h1;
  localparam logic [1:0] NOP_TWO_WORD = 2'h2;

  typedef enum logic [1:0] {IDLE_S, ARM_S, EXEC_S, NOP_S} ccs_state_type;

  // Recognises the complement opcode.
  function automatic logic isInvert(input logic [15:0] w);
    return w[15:10] == OPC_INVERT;
  endfunction : isInvert

  // Recognises the compare-and-skip-if-equal opcode.
  function automatic logic isSkipEq(input logic [15:0] w);
    return w[15:9] == OPC_SKIPEQ;
  endfunction : isSkipEq

endpackage : ccs_pkg

// ==== design/ccs_quarter_gen.sv ====
/*
  Quarter-cycle generator: splits each instruction cycle into Q1 to Q4.
  Assumes the core clock ticks once per quarter.
*/
`timescale 1ns/100ps
`default_nettype none
module ccs_quarter_gen (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic [1:0] quarter_r
);
  import ccs_pkg::*;

  logic [1:0] quarter_nxt;

  // The phase wraps from Q4 back to Q1.
  always_comb begin
    quarter_nxt = 2'(quarter_r + 2'h1);
  end

  // Phase register, Q1 after reset.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quarter_r <= Q_1;
    end else begin
      quarter_r <= quarter_nxt;
    end
  end
endmodule : ccs_quarter_gen
`default_nettype wire

// ==== design/ccs_data_mem.sv ====
/*
  Byte-wide data memory with one port and a registered read.
  Assumes the owner holds the address steady for the read it wants.
*/
`timescale 1ns/100ps
`default_nettype none
module ccs_data_mem (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ccs_pkg::MEM_AW-1:0] addr,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData_r
);
  import ccs_pkg::*;

  logic [7:0] store [2**MEM_AW];

  // Array write; the array itself has no reset.
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      store[addr] <= wrData;
    end
  end

  // Read data come out of a register one edge after the address.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= '0;
    end else begin
      rdData_r <= store[addr];
    end
  end
endmodule : ccs_data_mem
`default_nettype wire

// ==== bench/testbench.sv ====
/*
  Self-checking bench for the complement and compare-skip execution block.
  Assumes the block answers AXI4-Lite on clk_sys and is idle after reset.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ccs_pkg::*;
  logic clk_sys = 0;
  logic rstn = 0;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic awValid = 0, wValid = 0, arValid = 0;
  logic [31:0] wData = 32'h0000_0000;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData, seed = 32'h0000_0011;
  int error_cnt = 0, n_tests = 0, cyc = 0;

  // ----------------------------------------------------------------
  // Clock, design and timeout
  // ----------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;
  ccs_exec_top u_ccs_exec_top (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(1'h1), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'h1));
  // A hung handshake ends the run as a mismatch.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Compares one value with the model.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  // Xorshift step for the stimulus.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // One AXI4-Lite write; address and data offered together.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic aw, w;
    aw = 0;
    w = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && awReady === 1'h1) begin
        aw = 1;
        awValid <= 0;
      end
      if (!w && wReady === 1'h1) begin
        w = 1;
        wValid <= 0;
      end
    end
    do @(posedge clk_sys); while (bValid !== 1'h1);
    rsp = bResp;
  endtask : wr
  // One AXI4-Lite read.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    arAddr <= a;
    arValid <= 1;
    do @(posedge clk_sys); while (arReady !== 1'h1);
    arValid <= 0;
    do @(posedge clk_sys); while (rValid !== 1'h1);
    d = rData;
    rsp = rResp;
  endtask : rd

  // ----------------------------------------------------------------
  // Main sequence against the integer model
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, q, v;
    logic [1:0] rs, flg, flgE;
    logic op, d, a, ext, two, eq;
    logic [7:0] f, byt, acc, res, accE, memE;
    logic [11:0] ad, idx;
    logic [3:0] bank;
    logic [7:0] cyE;
    repeat (20) @(posedge clk_sys);
    rstn <= 1;
    @(posedge clk_sys);
    rd(OFS_ACC, v, rs);
    chk("acc reset", 32'h0000_0000, v);
    rd(8'h40, v, rs);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(8'h44, 32'h0000_0001, rs);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      q = seed;
      {op, d, a, ext, two} = r[4:0];
      f = r[15:8];
      byt = r[23:16];
      acc = r[5] ? byt : r[31:24];
      bank = q[3:0];
      idx = q[15:4];
      flg = q[17:16];
      // The first four runs straddle the indexed-offset limit.
      if (i < 4) begin
        a = 0;
        ext = 1;
        f = 8'h5E + i[7:0];
      end
      if (a) ad = {bank, f};
      else if (ext && f <= ILO_LIMIT) ad = idx + {4'h0, f};
      else ad = f < ACCESS_SPLIT ? {ACCESS_LO_BANK, f} : {ACCESS_HI_BANK, f};
      wr(OFS_CTRL, {31'h0, ext}, rs);
      wr(OFS_BANK, {28'h0, bank}, rs);
      wr(OFS_IDX, {20'h0, idx}, rs);
      wr(OFS_ACC, {24'h0, acc}, rs);
      wr(OFS_FLAGS, {30'h0, flg}, rs);
      wr(OFS_MADDR, {20'h0, ad}, rs);
      wr(OFS_MDATA, {24'h0, byt}, rs);
      if (op) wr(OFS_INSTR, {15'h0, two, OPC_INVERT, d, a, f}, rs);
      else wr(OFS_INSTR, {15'h0, two, OPC_SKIPEQ, a, f}, rs);
      for (int k = 0; k < 20; k++) begin
        rd(OFS_STAT, v, rs);
        if (v[STAT_BUSY_BIT] === 1'h0) break;
      end
      res = ~byt;
      eq = !op && byt == acc;
      accE = op && !d ? res : acc;
      memE = op && d ? res : byt;
      flgE = op ? {res[7], res == 8'h00} : flg;
      cyE = eq ? (two ? 8'h03 : 8'h02) : 8'h01;
      chk("busy", 32'h0000_0000, {31'h0, v[STAT_BUSY_BIT]});
      chk("cycles", {24'h0, cyE}, {24'h0, v[STAT_CYC_LSB +: 8]});
      chk("skip", {31'h0, eq}, {31'h0, v[STAT_SKIP_BIT]});
      rd(OFS_ACC, v, rs);
      chk("acc", {24'h0, accE}, {24'h0, v[7:0]});
      rd(OFS_FLAGS, v, rs);
      chk("flags", {30'h0, flgE}, {30'h0, v[1:0]});
      repeat (2) @(posedge clk_sys);
      rd(OFS_MDATA, v, rs);
      chk("byte", {24'h0, memE}, {24'h0, v[7:0]});
    end
    results();
  end
endmodule : testbench
`default_nettype wire
